// [design/rsf_pkg.sv]
// package: encodings, phases and carriers for the rotate/set datapath
package rsf_pkg;
  // ----------------------------------------
  // opcode prefixes, data and reset values, field and flag bit positions
  // ----------------------------------------
  localparam logic [5:0] RSF_OP6_RLN = 6'h11;
  localparam logic [5:0] RSF_OP6_RRN = 6'h10;
  localparam logic [6:0] RSF_OP7_SET = 7'h34;
  localparam logic [7:0] RSF_ALL_ONES = 8'hff;
  localparam logic [7:0] RSF_RESET_BYTE = 8'h00;
  localparam logic [3:0] RSF_RESET_BANK = 4'h0;
  localparam int RSF_DEST_BIT = 9;
  localparam int RSF_ACC_BIT = 8;
  localparam int RSF_FLAG_N = 4;
  localparam int RSF_FLAG_Z = 2;
  localparam logic [7:0] RSF_RESET_STATUS = 8'h00;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {RSF_Q1, RSF_Q2, RSF_Q3, RSF_Q4} rsf_phase_e;
  typedef enum logic [1:0] {RSF_K_NONE, RSF_K_RLN, RSF_K_RRN, RSF_K_SET} rsf_kind_e;

  typedef struct packed {
    rsf_kind_e kind;
    logic to_file;
    logic banked;
    logic [7:0] faddr;
  } rsf_dec_s;

  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] data;
  } rsf_wr_s;
endpackage : rsf_pkg

// [design/rsf_decode.sv]
// module: instruction word decoder for the rotate/set ops
`timescale 1ns/1ps
module rsf_decode (
  input wire logic [15:0] instr,
  output rsf_pkg::rsf_dec_s dec
);
  import rsf_pkg::*;
  always_comb begin
    dec.faddr = instr[7:0];
    dec.banked = instr[RSF_ACC_BIT];
    dec.to_file = instr[RSF_DEST_BIT];
    if (instr[15:10] == RSF_OP6_RRN) begin
      dec.kind = RSF_K_RRN;
    end else if (instr[15:10] == RSF_OP6_RLN) begin
      dec.kind = RSF_K_RLN;
    end else if (instr[15:9] == RSF_OP7_SET) begin
      dec.kind = RSF_K_SET;
      dec.to_file = 1'b1;
    end else begin
      dec.kind = RSF_K_NONE;
    end
  end
endmodule : rsf_decode

// [design/rsf_core.sv]
// module: four-phase execution datapath for rotate-no-carry and set-all-ones
`timescale 1ns/1ps
// How it works
// - rotate left: shift left one, old bit seven lands in bit zero
// - rotate right: shift right one, old bit zero lands in bit seven
// - destination bit zero writes accumulator, one writes back to source register
// - access bit zero uses access bank, one uses bank select register
// - rotates update only negative and zero flags from result
// - rotate right recognised by upper six opcode bits, then d, a, address
// - set op writes all ones to addressed register, flags untouched
// - eight-bit register address, single-bit destination and access selectors
// - one word per four clocks: decode, read, process, write phases
module rsf_core (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [15:0] instr,
  input wire logic [3:0] bank_select_register,
  input wire logic [7:0] rd_data,
  output logic [11:0] rd_addr,
  output logic rd_en,
  output rsf_pkg::rsf_wr_s file_wr,
  output logic [7:0] wreg_q,
  output logic [7:0] status_q,
  output rsf_pkg::rsf_phase_e phase_q,
  output logic done
);
  import rsf_pkg::*;

  // ----------------------------------------
  // phase sequencing
  // ----------------------------------------
  rsf_phase_e phase_d;
  rsf_dec_s dec, dec_q;
  logic [7:0] src_q, res_q;
  logic [7:0] res_d;

  always_comb begin
    case (phase_q)
      RSF_Q1: phase_d = RSF_Q2;
      RSF_Q2: phase_d = RSF_Q3;
      RSF_Q3: phase_d = RSF_Q4;
      RSF_Q4: phase_d = RSF_Q1;
      default: phase_d = RSF_Q1;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= RSF_Q1;
    end else begin
      phase_q <= phase_d;
    end
  end

  rsf_decode u_dec (
    .instr(instr),
    .dec(dec)
  );

  // instruction word only sampled in q1; it may change freely elsewhere
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      dec_q <= '0;
    end else if (phase_q == RSF_Q1) begin
      dec_q <= dec;
    end
  end

  // ----------------------------------------
  // addressing
  // ----------------------------------------
  function automatic logic [11:0] eff_addr(input rsf_dec_s d, input logic [3:0] bank);
    // access bank: low half in bank 0, high half in bank 15
    if (!d.banked) begin
      eff_addr = {{4{d.faddr[7]}}, d.faddr};
    end else begin
      eff_addr = {bank, d.faddr};
    end
  endfunction : eff_addr

  assign rd_addr = eff_addr(dec_q, bank_select_register);
  assign rd_en = (phase_q == RSF_Q2) && (dec_q.kind != RSF_K_NONE);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      src_q <= RSF_RESET_BYTE;
    end else if (phase_q == RSF_Q2) begin
      src_q <= rd_data;
    end
  end

  // ----------------------------------------
  // process
  // ----------------------------------------
  always_comb begin
    case (dec_q.kind)
      RSF_K_RLN: res_d = {src_q[6:0], src_q[7]};
      RSF_K_RRN: res_d = {src_q[0], src_q[7:1]};
      RSF_K_SET: res_d = RSF_ALL_ONES;
      default: res_d = src_q;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      res_q <= RSF_RESET_BYTE;
    end else if (phase_q == RSF_Q3) begin
      res_q <= res_d;
    end
  end

  // ----------------------------------------
  // write back
  // ----------------------------------------
  logic is_rot, wr_now;
  assign is_rot = (dec_q.kind == RSF_K_RLN) || (dec_q.kind == RSF_K_RRN);
  assign wr_now = (phase_q == RSF_Q4) && (dec_q.kind != RSF_K_NONE);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      file_wr <= '0;
    end else begin
      file_wr.we <= (phase_q == RSF_Q3) && (dec_q.kind != RSF_K_NONE) && dec_q.to_file;
      file_wr.addr <= rd_addr;
      file_wr.data <= res_d;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wreg_q <= RSF_RESET_BYTE;
    end else if (wr_now && is_rot && !dec_q.to_file) begin
      wreg_q <= res_q;
    end
  end

  // set op never touches flags
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      status_q <= RSF_RESET_STATUS;
    end else if (wr_now && is_rot) begin
      status_q[RSF_FLAG_N] <= res_q[7];
      status_q[RSF_FLAG_Z] <= (res_q == RSF_RESET_BYTE);
    end
  end

  assign done = wr_now;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_rot_left;
    phase_q == RSF_Q3 && dec_q.kind == RSF_K_RLN;
  endsequence

  chk_rotl_value: assert property (@(posedge clk) disable iff (!rstn)
    s_rot_left |=> res_q == {$past(src_q[6:0]), $past(src_q[7])})
    else $error("rotate left result wrong");
  chk_rotr_value: assert property (@(posedge clk) disable iff (!rstn)
    (phase_q == RSF_Q3 && dec_q.kind == RSF_K_RRN) |=> res_q == {$past(src_q[0]), $past(src_q[7:1])})
    else $error("rotate right result wrong");
  chk_wreg_dest: assert property (@(posedge clk) disable iff (!rstn)
    (wr_now && is_rot && !dec_q.to_file) |=> wreg_q == $past(res_q))
    else $error("accumulator not written");
  chk_file_dest: assert property (@(posedge clk) disable iff (!rstn)
    file_wr.we |-> phase_q == RSF_Q4 && dec_q.to_file && file_wr.data == res_q)
    else $error("file write at wrong moment");
  chk_bank_addr: assert property (@(posedge clk) disable iff (!rstn)
    (rd_en && dec_q.banked) |-> rd_addr[11:8] == bank_select_register)
    else $error("bank select ignored");
  chk_flag_zero: assert property (@(posedge clk) disable iff (!rstn)
    (wr_now && is_rot) |=> status_q[RSF_FLAG_Z] == ($past(res_q) == 8'h00))
    else $error("zero flag wrong");
  chk_flag_hold: assert property (@(posedge clk) disable iff (!rstn)
    !(wr_now && is_rot) |=> $stable(status_q))
    else $error("flags changed unexpectedly");
  chk_set_ones: assert property (@(posedge clk) disable iff (!rstn)
    (file_wr.we && dec_q.kind == RSF_K_SET) |-> file_wr.data == 8'hff)
    else $error("set op data not all ones");
  chk_phase_loop: assert property (@(posedge clk) disable iff (!rstn)
    phase_q == RSF_Q1 |=> phase_q == RSF_Q2 ##1 phase_q == RSF_Q3 ##1 phase_q == RSF_Q4 ##1 phase_q == RSF_Q1)
    else $error("phase order broken");

  // named steps of one group, reused by the checks below
  sequence s_write_phase;
    phase_q == RSF_Q4 && dec_q.kind != RSF_K_NONE;
  endsequence
  sequence s_rot_write;
    phase_q == RSF_Q4 && is_rot;
  endsequence
  sequence s_idle_read;
    phase_q == RSF_Q2 && dec_q.kind == RSF_K_NONE;
  endsequence

  chk_flag_neg: assert property (@(posedge clk) disable iff (!rstn)
    s_rot_write |=> status_q[RSF_FLAG_N] == $past(res_q[7]))
    else $error("negative flag wrong");
  chk_flag_others: assert property (@(posedge clk) disable iff (!rstn)
    s_rot_write |=> status_q[7:5] == $past(status_q[7:5]) && status_q[3] == $past(status_q[3])
      && status_q[1:0] == $past(status_q[1:0]))
    else $error("status bits beyond n and z changed");
  chk_access_bank: assert property (@(posedge clk) disable iff (!rstn)
    (rd_en && !dec_q.banked) |-> rd_addr[7:0] == dec_q.faddr
      && rd_addr[11:8] == (dec_q.faddr[7] ? 4'hf : 4'h0))
    else $error("access bank address wrong");
  chk_file_addr: assert property (@(posedge clk) disable iff (!rstn)
    file_wr.we |-> file_wr.addr == $past(rd_addr))
    else $error("write address differs from read address");
  chk_we_dest: assert property (@(posedge clk) disable iff (!rstn)
    s_write_phase |-> file_wr.we == dec_q.to_file)
    else $error("file write does not follow destination bit");
  chk_wreg_hold: assert property (@(posedge clk) disable iff (!rstn)
    !(wr_now && is_rot && !dec_q.to_file) |=> $stable(wreg_q))
    else $error("accumulator changed unexpectedly");
  chk_set_dest: assert property (@(posedge clk) disable iff (!rstn)
    (phase_q == RSF_Q4 && dec_q.kind == RSF_K_SET) |-> file_wr.we && file_wr.data == RSF_ALL_ONES)
    else $error("set op did not write the register");
  chk_refused_quiet: assert property (@(posedge clk) disable iff (!rstn)
    s_idle_read |-> !rd_en ##2 (!file_wr.we && !done))
    else $error("unrecognised word caused activity");
  chk_rd_window: assert property (@(posedge clk) disable iff (!rstn)
    rd_en |-> phase_q == RSF_Q2 && dec_q.kind != RSF_K_NONE)
    else $error("read outside read phase");
  chk_src_capture: assert property (@(posedge clk) disable iff (!rstn)
    phase_q == RSF_Q2 |=> src_q == $past(rd_data))
    else $error("source byte not captured");
  chk_dec_hold: assert property (@(posedge clk) disable iff (!rstn)
    phase_q != RSF_Q1 |=> $stable(dec_q))
    else $error("decoded word changed mid group");
  chk_we_pulse: assert property (@(posedge clk) disable iff (!rstn)
    file_wr.we |=> !file_wr.we)
    else $error("file write longer than one cycle");
  chk_done_pulse: assert property (@(posedge clk) disable iff (!rstn)
    done |=> !done)
    else $error("done longer than one cycle");
endmodule : rsf_core

// [dv/rsf_testbench.sv]
// testbench: reference model and checks for the rotate/set datapath
`timescale 1ns/1ps
module testbench;
  import rsf_pkg::*;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic clk, rstn;
  logic [15:0] instr;
  logic [3:0] bank_sel;
  logic [7:0] rd_data, wreg_q, status_q;
  logic [11:0] rd_addr;
  logic rd_en, done;
  rsf_wr_s file_wr;
  rsf_phase_e phase_q;
  int error_cnt = 0;
  int cmp_count = 0;
  logic [7:0] m_w = 8'h00;
  logic [7:0] m_st = 8'h00;

  rsf_core dut (.clk(clk), .rstn(rstn), .instr(instr), .bank_select_register(bank_sel), .rd_data(rd_data),
    .rd_addr(rd_addr), .rd_en(rd_en), .file_wr(file_wr), .wreg_q(wreg_q), .status_q(status_q),
    .phase_q(phase_q), .done(done));

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    cmp_count++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task conclude;
    if (error_cnt == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : conclude

  // bounded wait; phase must come round within eight negedge samples, two groups
  task to_q1;
    for (int i = 0; i < 8; i++) begin
      if (phase_q === RSF_Q1) return;
      @(negedge clk);
    end
    error_cnt++;
    conclude();
  endtask : to_q1

  // one instruction, model from the encodings themselves, not package constants
  task run_op(input logic [15:0] w, input logic [7:0] src);
    logic [7:0] res;
    logic isset, rec, tofile;
    logic [11:0] ea;
    isset = (w[15:9] == 7'b0110100);
    rec = isset || w[15:10] == 6'b010001 || w[15:10] == 6'b010000;
    res = isset ? 8'hff : (w[10] ? {src[6:0], src[7]} : {src[0], src[7:1]});
    tofile = isset | w[9];
    ea = w[8] ? {bank_sel, w[7:0]} : {{4{w[7]}}, w[7:0]};
    to_q1();
    instr = w;
    rd_data = src;
    @(negedge clk);
    chk("rd_en", {11'h000, rec}, {11'h000, rd_en});
    chk("phase", {10'h000, RSF_Q2}, {10'h000, phase_q});
    if (rec) chk("rd_addr", ea, rd_addr);
    @(negedge clk);
    @(negedge clk);
    chk("wr_we", {11'h000, rec & tofile}, {11'h000, file_wr.we});
    chk("done", {11'h000, rec}, {11'h000, done});
    if (rec && tofile) begin
      chk("wr_addr", ea, file_wr.addr);
      chk("wr_data", {4'h0, res}, {4'h0, file_wr.data});
    end
    if (rec && !isset) begin
      if (!w[9]) m_w = res;
      m_st = {3'b000, res[7], 1'b0, res == 8'h00, 2'b00};
    end
    @(negedge clk);
    chk("wreg", {4'h0, m_w}, {4'h0, wreg_q});
    chk("status", {4'h0, m_st}, {4'h0, status_q});
  endtask : run_op

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial begin
    logic [15:0] w;
    int k;
    instr = 16'h0000;
    bank_sel = 4'h0;
    rd_data = 8'h00;
    rstn = 1'b0;
    void'($urandom(19));
    repeat (6) @(negedge clk);
    rstn = 1'b1;
    chk("rst_status", 12'h000, {4'h0, status_q});
    bank_sel = 4'ha;
    run_op(16'h4680, 8'hab);
    run_op(16'h4080, 8'hd7);
    run_op(16'h4012, 8'hd7);
    run_op(16'h457f, 8'h00);
    run_op(16'h68ff, 8'h5a);
    run_op(16'h6900, 8'h5a);
    run_op(16'h3680, 8'h81);
    // random mix; bank changes between groups only, while rd_addr is unused
    for (int i = 0; i < 60; i++) begin
      k = $urandom_range(3);
      w = 16'($urandom);
      bank_sel = 4'($urandom);
      case (k)
        0: w[15:10] = 6'b010001;
        1: w[15:10] = 6'b010000;
        2: w[15:9] = 7'b0110100;
        default: ;
      endcase
      run_op(w, 8'($urandom));
    end
    conclude();
  end
endmodule : testbench
